/* vt_supervisor.v */
// voltage transformer supervisor: pick-up, angle shift check, fuse inputs, definite delay
// assumes magnitudes and angles from a front end on core_clk; fuse and block pins asynchronous
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "vt_supervisor_defines.vh"
`default_nettype none

module vt_supervisor #(
  parameter TIME_BASE_CYCLES = `TIME_BASE_CYC
) (
  input wire core_clk,
  input wire reset_n,
  input wire [7:0] channel_one_magnitude,
  input wire [7:0] channel_two_magnitude,
  input wire [7:0] channel_three_magnitude,
  input wire [7:0] channel_four_magnitude,
  input wire [7:0] positive_seq_magnitude,
  input wire [7:0] negative_seq_magnitude,
  input wire [7:0] zero_seq_magnitude,
  input wire [15:0] channel_one_angle,
  input wire [15:0] channel_two_angle,
  input wire [15:0] channel_three_angle,
  input wire [15:0] channel_four_angle,
  input wire [3:0] fuse_trip_pins,
  input wire block_pin,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  output wire irq,
  output reg [2:0] condition,
  output reg [2:0] bus_state,
  output reg start_out,
  output reg blocked_out,
  output reg bus_transformer_failure,
  output reg line_transformer_failure
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // ratio of threshold to magnitude in 1/256, saturated
  function [15:0] thr_ratio;
    input [7:0] thr;
    input [7:0] mag;
    reg [15:0] q;
    begin
      q = 16'h0000;
      if (mag == 8'h00) begin
        q = 16'hffff;
      end else begin
        q = {thr, 8'h00} / {8'h00, mag};
      end
      thr_ratio = q;
    end
  endfunction

  // absolute angle difference wrapped into 0..180 degrees (hundredths)
  function [15:0] ang_diff;
    input [15:0] a;
    input [15:0] b;
    reg [15:0] d;
    begin
      d = (a >= b) ? (a - b) : (b - a);
      if (d > 16'h4650) begin
        d = 16'h8ca0 - d;
      end
      ang_diff = d;
    end
  endfunction

  // ****************************************************************
  // input synchronisers for asynchronous pins
  // ****************************************************************
  reg [4:0] pin_meta_reg;
  reg [4:0] pin_sync_reg;
  // second stage only feeds logic; first stage is read by nothing else
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
    end else begin
      pin_meta_reg <= {block_pin, fuse_trip_pins};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ****************************************************************
  // program cycle divider: one enable pulse each 5 ms
  // ****************************************************************
  reg [19:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == (TIME_BASE_CYCLES - 1));
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= 20'h00000;
    end else if (tick) begin
      tick_cnt_reg <= 20'h00000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 20'h00001;
    end
  end

  // ****************************************************************
  // settings registers
  // ****************************************************************
  reg [7:0] low_pickup_reg;
  reg [7:0] high_detect_reg;
  reg [15:0] angle_limit_reg;
  reg [5:0] control_reg;
  reg [19:0] delay_reg;
  reg [3:0] irq_status_reg;
  reg [3:0] irq_mask_reg;
  wire [3:0] irq_event;

  // writes are clamped to the legal range so the comparators never see nonsense
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_pickup_reg <= `LOW_PICKUP_RST;
      high_detect_reg <= `HIGH_DETECT_RST;
      angle_limit_reg <= `ANGLE_LIMIT_RST;
      control_reg <= `CTL_RST;
      delay_reg <= `DELAY_RST;
      irq_mask_reg <= 4'h0;
    end else if (reg_write) begin
      case (reg_addr)
        `OFS_LOW_PICKUP: begin
          low_pickup_reg <= (reg_wdata[7:0] < `LOW_PICKUP_MIN) ? `LOW_PICKUP_MIN :
                            (reg_wdata[7:0] > `LOW_PICKUP_MAX) ? `LOW_PICKUP_MAX : reg_wdata[7:0];
        end
        `OFS_HIGH_DETECT: begin
          high_detect_reg <= (reg_wdata[7:0] < `HIGH_DETECT_MIN) ? `HIGH_DETECT_MIN :
                             (reg_wdata[7:0] > `HIGH_DETECT_MAX) ? `HIGH_DETECT_MAX : reg_wdata[7:0];
        end
        `OFS_ANGLE_LIMIT: begin
          angle_limit_reg <= (reg_wdata[15:0] < `ANGLE_LIMIT_MIN) ? `ANGLE_LIMIT_MIN :
                             (reg_wdata[15:0] > `ANGLE_LIMIT_MAX) ? `ANGLE_LIMIT_MAX :
                             (reg_wdata[15:0] - (reg_wdata[15:0] % `ANGLE_STEP));
        end
        `OFS_CONTROL: begin
          control_reg <= reg_wdata[5:0];
        end
        `OFS_DELAY: begin
          delay_reg <= (reg_wdata[19:0] > `DELAY_MAX) ? `DELAY_MAX : reg_wdata[19:0];
        end
        `OFS_IRQ_MASK: begin
          irq_mask_reg <= reg_wdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // sticky events; a new event wins over a write-one clear in the same cycle
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= 4'h0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~((reg_write && reg_addr == `OFS_IRQ_STATUS) ?
                        reg_wdata[3:0] : 4'h0)) | irq_event;
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  // ****************************************************************
  // measurement sampling on the program cycle
  // ****************************************************************
  reg [7:0] mag_reg [0:3];
  reg [15:0] ang_reg [0:3];
  reg [7:0] pos_seq_reg;
  reg [7:0] neg_seq_reg;
  reg [7:0] zero_seq_reg;
  reg block_smp_reg;
  reg [4:0] fill_reg;
  wire [31:0] mag_in = {channel_four_magnitude, channel_three_magnitude,
                        channel_two_magnitude, channel_one_magnitude};
  wire [63:0] ang_in = {channel_four_angle, channel_three_angle, channel_two_angle, channel_one_angle};

  // magnitudes and angles are taken once per 5 ms cycle
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_seq_reg <= 8'h00;
      neg_seq_reg <= 8'h00;
      zero_seq_reg <= 8'h00;
      block_smp_reg <= 1'b0;
    end else if (tick) begin
      pos_seq_reg <= positive_seq_magnitude;
      neg_seq_reg <= negative_seq_magnitude;
      zero_seq_reg <= zero_seq_magnitude;
      block_smp_reg <= pin_sync_reg[4];
    end
  end

  // angle history: eight program cycles make up 40 ms
  reg [15:0] hist_reg [0:3][0:7];
  reg [15:0] diff_reg [0:3];
  wire [3:0] shift_small;
  genvar gc;
  generate
    for (gc = 0; gc < 4; gc = gc + 1) begin : g_chan
      integer k;
      always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          mag_reg[gc] <= 8'h00;
          ang_reg[gc] <= 16'h0000;
          diff_reg[gc] <= 16'h0000;
          for (k = 0; k < 8; k = k + 1) begin
            hist_reg[gc][k] <= 16'h0000;
          end
        end else if (tick) begin
          mag_reg[gc] <= mag_in[gc*8 +: 8];
          ang_reg[gc] <= ang_in[gc*16 +: 16];
          hist_reg[gc][0] <= ang_in[gc*16 +: 16];
          for (k = 1; k < 8; k = k + 1) begin
            hist_reg[gc][k] <= hist_reg[gc][k-1];
          end
          diff_reg[gc] <= ang_diff(ang_in[gc*16 +: 16], hist_reg[gc][7]);
        end
      end
      assign shift_small[gc] = diff_reg[gc] < angle_limit_reg;
    end
  endgenerate

  // history fill counter: no inhibit decision until 40 ms of angles exist
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fill_reg <= 5'h00;
    end else if (tick && fill_reg <= `ANGLE_HIST_TICKS) begin
      fill_reg <= fill_reg + 5'h01;
    end
  end

  // ****************************************************************
  // pick-up evaluation; settings read live so a group change acts at once
  // ****************************************************************
  wire [2:0] low_hit;
  wire [2:0] high_hit;
  wire [2:0] in_limits;
  generate
    for (gc = 0; gc < 3; gc = gc + 1) begin : g_phase
      assign low_hit[gc] = mag_reg[gc] < low_pickup_reg;
      assign high_hit[gc] = mag_reg[gc] > high_detect_reg;
      assign in_limits[gc] = !low_hit[gc] && mag_reg[gc] <= `HIGH_DETECT_MAX;
    end
  endgenerate
  wire two_high = (high_hit[0] & high_hit[1]) | (high_hit[0] & high_hit[2]) | (high_hit[1] & high_hit[2]);
  wire angle_inhibit = (fill_reg > `ANGLE_HIST_TICKS) && (&shift_small[2:0]);
  wire pickup = (|low_hit) && two_high && !angle_inhibit;
  wire bus_fuse = control_reg[`CTL_BUS_FUSE_EN] &&
                  pin_sync_reg[control_reg[`CTL_BUS_SEL_LO +: 2]];
  wire line_fuse = control_reg[`CTL_LINE_FUSE_EN] &&
                   pin_sync_reg[control_reg[`CTL_LINE_SEL_LO +: 2]];
  wire all_dead = (mag_reg[0] < low_pickup_reg) && (mag_reg[1] < low_pickup_reg) &&
                  (mag_reg[2] < low_pickup_reg);

  // threshold ratios per phase, recomputed on each program cycle tick
  reg [15:0] ratio_reg [0:2];
  integer p;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (p = 0; p < 3; p = p + 1) begin
        ratio_reg[p] <= 16'h0000;
      end
    end else if (tick) begin
      for (p = 0; p < 3; p = p + 1) begin
        ratio_reg[p] <= thr_ratio(low_pickup_reg, mag_reg[p]);
      end
    end
  end

  // ****************************************************************
  // condition machine with definite delay
  // ****************************************************************
  localparam [3:0] ST_NORMAL = 4'b0001;
  localparam [3:0] ST_START = 4'b0010;
  localparam [3:0] ST_FAIL = 4'b0100;
  localparam [3:0] ST_BLOCKED = 4'b1000;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [19:0] elapsed_reg;
  reg [19:0] elapsed_next;

  // evaluated only on the program cycle tick; block is the value sampled at cycle start
  always @* begin
    state_next = state_reg;
    elapsed_next = elapsed_reg;
    if (tick) begin
      case (state_reg)
        ST_NORMAL: begin
          if (pickup && block_smp_reg) begin
            state_next = ST_BLOCKED;
          end else if (pickup) begin
            state_next = ST_START;
            elapsed_next = 20'h00000;
          end
        end
        ST_START: begin
          if (!pickup || block_smp_reg) begin
            state_next = ST_NORMAL;
            elapsed_next = 20'h00000;
          end else if (elapsed_reg + 20'h00001 >= delay_reg) begin
            state_next = ST_FAIL;
            elapsed_next = delay_reg;
          end else begin
            elapsed_next = elapsed_reg + 20'h00001;
          end
        end
        ST_FAIL: begin
          if (!pickup) begin
            state_next = ST_NORMAL;
            elapsed_next = 20'h00000;
          end
        end
        ST_BLOCKED: begin
          if (!pickup) begin
            state_next = ST_NORMAL;
          end
        end
        default: begin
          state_next = ST_NORMAL;
          elapsed_next = 20'h00000;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_NORMAL;
      elapsed_reg <= 20'h00000;
    end else begin
      state_reg <= state_next;
      elapsed_reg <= elapsed_next;
    end
  end

  // remaining time in 5 ms steps, signed; negative once delay is written below the elapsed count
  wire signed [20:0] remaining = $signed({1'b0, delay_reg}) - $signed({1'b0, elapsed_reg});

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  reg [2:0] cond_next;
  reg [2:0] bus_next;
  always @* begin
    cond_next = `COND_NORMAL;
    if (state_reg == ST_BLOCKED) begin
      cond_next = `COND_BLOCKED;
    end else if (line_fuse) begin
      cond_next = `COND_LINE_FAIL;
    end else if (state_reg == ST_FAIL || bus_fuse) begin
      cond_next = `COND_BUS_FAIL;
    end else if (state_reg == ST_START) begin
      cond_next = `COND_START;
    end
    if (pickup || bus_fuse || line_fuse) begin
      bus_next = `BUS_LIVE_PROBLEM;
    end else if (all_dead) begin
      bus_next = `BUS_DEAD;
    end else if (!(&in_limits) || neg_seq_reg > pos_seq_reg) begin
      bus_next = (neg_seq_reg > pos_seq_reg) ? `BUS_LIVE_REV : `BUS_LIVE_UNDEF;
    end else if (neg_seq_reg == pos_seq_reg || zero_seq_reg > pos_seq_reg) begin
      bus_next = `BUS_LIVE_UNDEF;
    end else begin
      bus_next = `BUS_LIVE_OK;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      condition <= `COND_NORMAL;
      bus_state <= `BUS_DEAD;
      start_out <= 1'b0;
      blocked_out <= 1'b0;
      bus_transformer_failure <= 1'b0;
      line_transformer_failure <= 1'b0;
    end else begin
      condition <= cond_next;
      bus_state <= bus_next;
      start_out <= state_reg == ST_START;
      blocked_out <= state_reg == ST_BLOCKED;
      bus_transformer_failure <= state_reg == ST_FAIL || bus_fuse;
      line_transformer_failure <= line_fuse;
    end
  end

  assign irq_event = {state_next == ST_BLOCKED && state_reg != ST_BLOCKED,
                      line_fuse && !line_transformer_failure,
                      state_next == ST_FAIL && state_reg != ST_FAIL,
                      state_next == ST_START && state_reg != ST_START};

  // ****************************************************************
  // register read port, data one cycle after the strobe
  // ****************************************************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      case (reg_addr)
        `OFS_LOW_PICKUP: reg_rdata <= {24'h000000, low_pickup_reg};
        `OFS_HIGH_DETECT: reg_rdata <= {24'h000000, high_detect_reg};
        `OFS_ANGLE_LIMIT: reg_rdata <= {16'h0000, angle_limit_reg};
        `OFS_CONTROL: reg_rdata <= {26'h0000000, control_reg};
        `OFS_DELAY: reg_rdata <= {12'h000, delay_reg};
        `OFS_STATUS: reg_rdata <= {24'h000000, 2'h0, bus_state, condition};
        `OFS_IRQ_STATUS: reg_rdata <= {28'h0000000, irq_status_reg};
        `OFS_IRQ_MASK: reg_rdata <= {28'h0000000, irq_mask_reg};
        `OFS_REMAINING: reg_rdata <= {{11{remaining[20]}}, remaining};
        `OFS_RATIO_A: reg_rdata <= {16'h0000, ratio_reg[0]};
        `OFS_RATIO_B: reg_rdata <= {16'h0000, ratio_reg[1]};
        `OFS_RATIO_C: reg_rdata <= {16'h0000, ratio_reg[2]};
        `OFS_ANGLE_DIFF: reg_rdata <= {diff_reg[1], diff_reg[0]};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // vt_supervisor

`default_nettype wire

/* vt_supervisor_defines.vh */
// constants for the voltage transformer supervisor: settings, offsets, codes, timing
// assumes a 125 MHz core clock and magnitudes scaled in hundredths of nominal voltage
`ifndef VT_SUPERVISOR_DEFINES_VH
`define VT_SUPERVISOR_DEFINES_VH

// ****************************************************************
// register offsets (word index on the plain register port)
// ****************************************************************
`define OFS_LOW_PICKUP 4'h0
`define OFS_HIGH_DETECT 4'h1
`define OFS_ANGLE_LIMIT 4'h2
`define OFS_CONTROL 4'h3
`define OFS_DELAY 4'h4
`define OFS_STATUS 4'h5
`define OFS_IRQ_STATUS 4'h6
`define OFS_IRQ_MASK 4'h7
`define OFS_REMAINING 4'h8
`define OFS_RATIO_A 4'h9
`define OFS_RATIO_B 4'ha
`define OFS_RATIO_C 4'hb
`define OFS_ANGLE_DIFF 4'hc

// ****************************************************************
// settings: voltages in 0.01 x nominal, angles in 0.01 degree
// ****************************************************************
`define LOW_PICKUP_MIN 8'h05
`define LOW_PICKUP_MAX 8'h32
`define LOW_PICKUP_RST 8'h05
`define HIGH_DETECT_MIN 8'h01
`define HIGH_DETECT_MAX 8'h6e
`define HIGH_DETECT_RST 8'h50
`define ANGLE_LIMIT_MIN 16'h00c8
`define ANGLE_LIMIT_MAX 16'h2328
`define ANGLE_LIMIT_RST 16'h01f4
`define ANGLE_STEP 16'h000a
`define DELAY_MAX 20'h57e40
`define DELAY_RST 20'h000c8

// control register bit positions
`define CTL_BUS_FUSE_EN 0
`define CTL_LINE_FUSE_EN 1
`define CTL_BUS_SEL_LO 2
`define CTL_LINE_SEL_LO 4
`define CTL_RST 6'h03

// interrupt bits
`define IRQ_START 0
`define IRQ_BUS_FAIL 1
`define IRQ_LINE_FAIL 2
`define IRQ_BLOCKED 3

// condition codes
`define COND_NORMAL 3'h0
`define COND_START 3'h1
`define COND_LINE_FAIL 3'h2
`define COND_BUS_FAIL 3'h3
`define COND_BLOCKED 3'h4

// bus state codes
`define BUS_DEAD 3'h0
`define BUS_LIVE_OK 3'h1
`define BUS_LIVE_REV 3'h2
`define BUS_LIVE_UNDEF 3'h3
`define BUS_LIVE_PROBLEM 3'h4

// ****************************************************************
// timing
// ****************************************************************
`define CLK_MHZ 125
`define TIME_BASE_US 5000
`define TIME_BASE_CYC (`TIME_BASE_US * `CLK_MHZ)
`define ANGLE_HIST_MS 40
`define ANGLE_HIST_TICKS (`ANGLE_HIST_MS * 1000 / `TIME_BASE_US)

`endif

/* vt_supervisor_asserts.sv */
// port checker for the voltage transformer supervisor
// assumes a bind from the bench top and the shared defines header
`timescale 1ns/1ps
`default_nettype none
`include "vt_supervisor_defines.vh"
// ****************************************
// checker
// ****************************************
module vt_supervisor_asserts #(
  parameter int TIME_BASE_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] fuse_trip_pins,
  input wire logic block_pin,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0] condition,
  input wire logic [2:0] bus_state,
  input wire logic start_out,
  input wire logic blocked_out,
  input wire logic bus_transformer_failure
);
  int fuse_age_reg;
  int block_age_reg;
  int cond_age_reg;
  // ages saturate so a long quiet run never wraps
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_age_reg <= 0;
      block_age_reg <= 999;
      cond_age_reg <= 0;
    end else begin
      fuse_age_reg <= (fuse_trip_pins != 4'h0) ? 0 : (fuse_age_reg < 999 ? fuse_age_reg + 1 : 999);
      block_age_reg <= block_pin ? 0 : (block_age_reg < 999 ? block_age_reg + 1 : 999);
      cond_age_reg <= $changed(condition) ? 0 : (cond_age_reg < 999 ? cond_age_reg + 1 : 999);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_start_code: assert property (start_out == (condition == `COND_START))
    else $error("start flag and condition disagree");
  a_blocked_code: assert property (blocked_out == (condition == `COND_BLOCKED))
    else $error("blocked flag and condition disagree");
  a_busfail_code: assert property (condition == `COND_BUS_FAIL |-> bus_transformer_failure)
    else $error("bus fail code without flag");
  a_start_problem: assert property ($rose(start_out) |-> bus_state == `BUS_LIVE_PROBLEM)
    else $error("start without problem state");
  a_dead_quiet: assert property (bus_state == `BUS_DEAD |-> !start_out)
    else $error("start on a dead bus");
  // fuse pins act off the tick, so those spans are skipped
  a_fail_after_start: assert property ($rose(bus_transformer_failure) && fuse_age_reg >= 8 |-> $past(start_out))
    else $error("failure without prior start");
  a_blocked_cause: assert property ($rose(blocked_out) |-> block_age_reg <= TIME_BASE_CYCLES + 6)
    else $error("blocked without block input");
  a_tick_pacing: assert property ($changed(condition) && fuse_age_reg >= 8 |-> cond_age_reg >= TIME_BASE_CYCLES - 2)
    else $error("condition moved between ticks");
  cover property ($rose(start_out));
  cover property ($rose(bus_transformer_failure));
  cover property ($rose(blocked_out));
endmodule // vt_supervisor_asserts
`default_nettype wire

/* vt_front_end.sv */
// measurement front end model: magnitudes, sequence voltages, angles
// assumes the bench picks a scene; angles spin steadily
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// front end
// ****************************************
module vt_front_end (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [2:0] mode,
  output logic [7:0] m1,
  output logic [7:0] m2,
  output logic [7:0] m3,
  output logic [7:0] m4,
  output logic [7:0] sp,
  output logic [7:0] sn,
  output logic [7:0] sz,
  output logic [15:0] a1,
  output logic [15:0] a2,
  output logic [15:0] a3,
  output logic [15:0] a4
);
  logic [15:0] base_reg;
  // 0.1 deg per cycle: well past the reset shift limit over the history span
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) base_reg <= 16'h0;
    else base_reg <= (base_reg >= 16'h8c96) ? 16'h0 : base_reg + 16'h000a;
  end
  assign a1 = base_reg;
  assign a2 = (base_reg + 16'h2ee0) % 16'h8ca0;
  assign a3 = (base_reg + 16'h5dc0) % 16'h8ca0;
  assign a4 = base_reg;
  // 0 dead, 1 healthy, 2 reversed, 3 undefined, 4 lost phase, 5 sagging phase
  always_comb begin
    {m1, m2, m3, m4, sp, sn, sz} = {8'h64, 8'h64, 8'h64, 8'h64, 8'h64, 8'h00, 8'h00};
    case (mode)
      3'h0: {m1, m2, m3, m4, sp} = 40'h0;
      3'h2: {sp, sn} = {8'h0a, 8'h64};
      3'h3: {sp, sz} = {8'h00, 8'h32};
      3'h4: m1 = 8'h00;
      3'h5: m1 = 8'h14;
      default: ;
    endcase
  end
endmodule // vt_front_end
`default_nettype wire

/* vt_supervisor_test.sv */
// self-checking bench for the voltage transformer supervisor
// assumes the front end model and the checker are compiled beside it
`timescale 1ns/1ps
`default_nettype none
`include "vt_supervisor_defines.vh"
// ****************************************
// bench
// ****************************************
module vt_supervisor_test;
  localparam int T = 20;
  logic core_clk, reset_n, block_pin, reg_write, reg_read, irq, start_out, blocked_out;
  logic bus_transformer_failure, line_transformer_failure;
  logic [2:0] mode, condition, bus_state;
  logic [3:0] fuse_trip_pins, reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] m1, m2, m3, m4, sp, sn, sz;
  logic [15:0] a1, a2, a3, a4;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  vt_front_end front (.core_clk(core_clk), .reset_n(reset_n), .mode(mode), .m1(m1), .m2(m2), .m3(m3),
    .m4(m4), .sp(sp), .sn(sn), .sz(sz), .a1(a1), .a2(a2), .a3(a3), .a4(a4));
  vt_supervisor #(.TIME_BASE_CYCLES(T)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .channel_one_magnitude(m1), .channel_two_magnitude(m2), .channel_three_magnitude(m3),
    .channel_four_magnitude(m4), .positive_seq_magnitude(sp), .negative_seq_magnitude(sn),
    .zero_seq_magnitude(sz), .channel_one_angle(a1), .channel_two_angle(a2), .channel_three_angle(a3),
    .channel_four_angle(a4), .fuse_trip_pins(fuse_trip_pins), .block_pin(block_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .condition(condition), .bus_state(bus_state), .start_out(start_out), .blocked_out(blocked_out),
    .bus_transformer_failure(bus_transformer_failure), .line_transformer_failure(line_transformer_failure));
  task automatic close_out;
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic scene(input logic [2:0] m, input int n);
    @(posedge core_clk);
    mode <= m;
    repeat (n * T) @(posedge core_clk);
    #1;
  endtask
  task automatic outs(input logic [2:0] c, input logic s, input logic b, input logic f);
    chk("condition", 32'(c), 32'(condition));
    chk("start_out", 32'(s), 32'(start_out));
    chk("blocked_out", 32'(b), 32'(blocked_out));
    chk("bus_transformer_failure", 32'(f), 32'(bus_transformer_failure));
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // hang guard: the run needs about 1400 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    logic [31:0] rst_val [0:4];
    logic [2:0] states [0:3];
    rst_val = '{32'(`LOW_PICKUP_RST), 32'(`HIGH_DETECT_RST), 32'(`ANGLE_LIMIT_RST), 32'(`CTL_RST), 32'(`DELAY_RST)};
    states = '{`BUS_DEAD, `BUS_LIVE_OK, `BUS_LIVE_REV, `BUS_LIVE_UNDEF};
    {reset_n, block_pin, reg_write, reg_read, fuse_trip_pins, reg_addr, reg_wdata} = '0;
    mode = 3'h1;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd(4'(i), rst_val[i]);
    rd(`OFS_IRQ_MASK, 32'h0);
    rd(4'hd, 32'h0);
    // out-of-range settings clamp, angle rounds down
    wr(`OFS_LOW_PICKUP, 32'h60);
    rd(`OFS_LOW_PICKUP, 32'(`LOW_PICKUP_MAX));
    wr(`OFS_HIGH_DETECT, 32'h0);
    rd(`OFS_HIGH_DETECT, 32'(`HIGH_DETECT_MIN));
    wr(`OFS_HIGH_DETECT, 32'(`HIGH_DETECT_RST));
    wr(`OFS_ANGLE_LIMIT, 32'hcd);
    rd(`OFS_ANGLE_LIMIT, 32'(`ANGLE_LIMIT_MIN));
    wr(`OFS_ANGLE_LIMIT, 32'h2328);
    wr(`OFS_LOW_PICKUP, 32'(`LOW_PICKUP_RST));
    for (int i = 0; i < 4; i++) begin
      scene(3'(i), 3);
      chk("bus_state", 32'(states[i]), 32'(bus_state));
    end
    // sagging phase: the wide shift limit inhibits until set back
    rd(`OFS_RATIO_A, 32'hc);
    wr(`OFS_LOW_PICKUP, 32'h32);
    scene(3'h5, 3);
    outs(`COND_NORMAL, 1'b0, 1'b0, 1'b0);
    wr(`OFS_ANGLE_LIMIT, 32'(`ANGLE_LIMIT_RST));
    scene(3'h5, 3);
    outs(`COND_START, 1'b1, 1'b0, 1'b0);
    rd(`OFS_RATIO_A, 32'h280);
    wr(`OFS_LOW_PICKUP, 32'(`LOW_PICKUP_RST));
    wr(`OFS_DELAY, 32'h4);
    wr(`OFS_IRQ_MASK, 32'hf);
    scene(3'h1, 3);
    wr(`OFS_IRQ_STATUS, 32'hf);
    scene(3'h4, 3);
    outs(`COND_START, 1'b1, 1'b0, 1'b0);
    chk("bus_state", 32'(`BUS_LIVE_PROBLEM), 32'(bus_state));
    rd(`OFS_RATIO_A, 32'hffff);
    scene(3'h4, 4);
    outs(`COND_BUS_FAIL, 1'b0, 1'b0, 1'b1);
    chk("irq", 32'h1, 32'(irq));
    rd(`OFS_IRQ_STATUS, 32'h3);
    rd(`OFS_REMAINING, 32'h0);
    scene(3'h1, 3);
    outs(`COND_NORMAL, 1'b0, 1'b0, 1'b0);
    wr(`OFS_IRQ_STATUS, 32'hf);
    rd(`OFS_IRQ_STATUS, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    // masked: status records, pick-up drops early
    wr(`OFS_IRQ_MASK, 32'h0);
    wr(`OFS_DELAY, 32'h8);
    scene(3'h4, 3);
    chk("irq", 32'h0, 32'(irq));
    rd(`OFS_IRQ_STATUS, 32'h1);
    scene(3'h1, 12);
    outs(`COND_NORMAL, 1'b0, 1'b0, 1'b0);
    block_pin <= 1'b1;
    wr(`OFS_IRQ_STATUS, 32'hf);
    scene(3'h4, 3);
    outs(`COND_BLOCKED, 1'b0, 1'b1, 1'b0);
    rd(`OFS_IRQ_STATUS, 32'h8);
    scene(3'h4, 10);
    outs(`COND_BLOCKED, 1'b0, 1'b1, 1'b0);
    block_pin <= 1'b0;
    scene(3'h1, 3);
    // fuse inputs: ignored when unchecked, else routed by pin select
    wr(`OFS_CONTROL, 32'h0);
    fuse_trip_pins <= 4'h6;
    scene(3'h1, 2);
    chk("bus_transformer_failure", 32'h0, 32'(bus_transformer_failure));
    chk("line_transformer_failure", 32'h0, 32'(line_transformer_failure));
    wr(`OFS_CONTROL, 32'h1b);
    scene(3'h1, 2);
    chk("bus_transformer_failure", 32'h1, 32'(bus_transformer_failure));
    chk("line_transformer_failure", 32'h1, 32'(line_transformer_failure));
    close_out();
  end
endmodule // vt_supervisor_test
bind vt_supervisor vt_supervisor_asserts #(.TIME_BASE_CYCLES(TIME_BASE_CYCLES)) checker_inst (
  .core_clk(core_clk), .reset_n(reset_n), .fuse_trip_pins(fuse_trip_pins), .block_pin(block_pin),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .condition(condition), .bus_state(bus_state),
  .start_out(start_out), .blocked_out(blocked_out), .bus_transformer_failure(bus_transformer_failure));
`default_nettype wire
